/* hdl/ccod_pkg.sv */
// constants and types for the control opcode and operand decoder
package ccod_pkg;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hf8;
  localparam logic [7:0] OP_CARRY_SET = 8'hf9;
  localparam logic [7:0] OP_CARRY_INVERT = 8'hf5;
  localparam logic [7:0] OP_DIR_CLEAR = 8'hfc;
  localparam logic [7:0] OP_DIR_SET = 8'hfd;
  localparam logic [7:0] OP_INT_DISABLE = 8'hfa;
  localparam logic [7:0] OP_INT_ENABLE = 8'hfb;
  localparam logic [7:0] OP_HALT = 8'hf4;
  localparam logic [7:0] OP_WAIT = 8'h9b;
  localparam logic [7:0] OP_LOCK = 8'hf0;
  localparam logic [7:0] OP_NOP = 8'h90;
  localparam logic [7:0] SEG_PFX_MASK = 8'he7;
  localparam logic [7:0] SEG_PFX_VAL = 8'h26;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  localparam logic [3:0] CYC_FLAG_OP = 4'h2;
  localparam logic [3:0] CYC_LOCK = 4'h2;
  localparam logic [3:0] CYC_HALT = 4'h2;
  localparam logic [3:0] CYC_WAIT = 4'h6;
  localparam logic [3:0] CYC_NOP = 4'h3;
  localparam logic [3:0] CYC_EA = 4'h4;
  localparam logic [3:0] CYC_WORD_XFER = 4'h4;
  // register indices, also the 8-bit names
  localparam logic [2:0] R_AX = 3'h0;
  localparam logic [2:0] R_CX = 3'h1;
  localparam logic [2:0] R_DX = 3'h2;
  localparam logic [2:0] R_BX = 3'h3;
  localparam logic [2:0] R_SP = 3'h4;
  localparam logic [2:0] R_BP = 3'h5;
  localparam logic [2:0] R_SI = 3'h6;
  localparam logic [2:0] R_DI = 3'h7;
  typedef enum logic [2:0] {
    CCOD_IDLE = 3'b000,
    CCOD_MODRM = 3'b001,
    CCOD_DISP_LO = 3'b010,
    CCOD_DISP_HI = 3'b011,
    CCOD_BUSY = 3'b100,
    CCOD_HALTED = 3'b101,
    CCOD_WAITING = 3'b110
  } ccod_state_t;
endpackage : ccod_pkg

/* hdl/ccod_ea_calc.sv */
// effective address adder for the mod and r/m fields
`timescale 1ns/1ps
module ccod_ea_calc (
  input wire logic [1:0] mod_i,
  input wire logic [2:0] rm_i,
  input wire logic [15:0] disp_i,
  input wire logic [15:0] bx_i,
  input wire logic [15:0] bp_i,
  input wire logic [15:0] si_i,
  input wire logic [15:0] di_i,
  output logic [15:0] ea_o,
  output logic uses_bp_o
);
  import ccod_pkg::*;
  always_comb begin
    ea_o = disp_i;
    uses_bp_o = 1'b0;
    case (rm_i)
      3'h0: ea_o = 16'(bx_i + si_i + disp_i);
      3'h1: ea_o = 16'(bx_i + di_i + disp_i);
      3'h2: begin
        ea_o = 16'(bp_i + si_i + disp_i);
        uses_bp_o = 1'b1;
      end
      3'h3: begin
        ea_o = 16'(bp_i + di_i + disp_i);
        uses_bp_o = 1'b1;
      end
      3'h4: ea_o = 16'(si_i + disp_i);
      3'h5: ea_o = 16'(di_i + disp_i);
      3'h6: begin
        // direct form adds nothing
        if (mod_i == MOD_NODISP) begin
          ea_o = disp_i;
        end else begin
          ea_o = 16'(bp_i + disp_i);
          uses_bp_o = 1'b1;
        end
      end
      default: ea_o = 16'(bx_i + disp_i);
    endcase
  end
endmodule : ccod_ea_calc

/* hdl/ccod_decoder.sv */
// control opcode and operand decoder of the processor core
// ----------------------------------------------------------------
// Functional notes
// - f8 clears carry, f9 sets it, f5 inverts it; 2 cycles each.
// - fc clears direction flag, fd sets it; 2 cycles each.
// - fa clears interrupt enable, fb sets it; 2 cycles each.
// - f0 is lock prefix, 2 cycles; next instruction's bus activity locked.
// - word memory transfers cost 4 cycles more than byte figures.
// - mod 11 makes r/m a register selector.
// - mod 00 means zero displacement, no bytes, except direct form.
// - mod 01 fetches one byte sign-extended to 16 bits.
// - mod 10 fetches 16-bit displacement, low byte first.
// - r/m 000-011 add displacement to base plus index pair.
// - r/m 100-111 add displacement to si, di, bp, bx.
// - mod 00 with r/m 110 is direct address, displacement only.
// - displacement follows the second byte, before immediate data.
// - address calculation takes 4 cycles, included in execution time.
// - byte 001ss110 is segment override: es, cs, ss, ds.
// - reg codes select 16-bit or 8-bit registers by size bit.
// - operands addressed via base pointer default to stack segment.
// - string destinations via di always use extra segment, no override.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module ccod_decoder (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic modrm_op_i,
  input wire logic word_op_i,
  input wire logic mem_xfer_i,
  input wire logic string_dest_i,
  input wire logic test_active_i,
  input wire logic [15:0] bx_i,
  input wire logic [15:0] bp_i,
  input wire logic [15:0] si_i,
  input wire logic [15:0] di_i,
  output logic byte_ready_o,
  output logic carry_o,
  output logic direction_o,
  output logic int_enable_o,
  output logic halted_o,
  output logic bus_lock_o,
  output logic ea_valid_o,
  output logic [15:0] effective_address_o,
  output logic [1:0] segment_o,
  output logic reg_operand_o,
  output logic [2:0] reg_sel_o,
  output logic reg_wide_o,
  output logic [15:0] disp_o
);
  import ccod_pkg::*;

  typedef struct packed {
    ccod_state_t st;
    logic [3:0] cnt;
    logic carry;
    logic dir;
    logic ie;
    logic halted;
    logic lock_pend;
    logic lock;
    logic seg_ovr;
    logic [1:0] seg_ovr_sel;
    logic [1:0] mod;
    logic [2:0] rm;
    logic [15:0] disp;
    logic ea_valid;
    logic [15:0] ea;
    logic [1:0] seg;
    logic reg_op;
    logic [2:0] reg_sel;
    logic reg_wide;
    logic wide;
    logic str_dst;
  } ccod_regs_t;

  ccod_regs_t s_r;
  ccod_regs_t s_nxt;
  logic [15:0] ea_calc;
  logic uses_bp;

  ccod_ea_calc u_ea (
    .mod_i(s_r.mod),
    .rm_i(s_r.rm),
    .disp_i(s_r.disp),
    .bx_i(bx_i),
    .bp_i(bp_i),
    .si_i(si_i),
    .di_i(di_i),
    .ea_o(ea_calc),
    .uses_bp_o(uses_bp)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ea_valid = 1'b0;
    case (s_r.st)
      CCOD_IDLE: begin
        if (byte_valid_i) begin
          // count starts two short: the taking edge is the first cycle, the zero count the last
          s_nxt.cnt = CYC_FLAG_OP - 4'h2;
          s_nxt.st = CCOD_BUSY;
          s_nxt.wide = word_op_i;
          s_nxt.str_dst = string_dest_i;
          if ((byte_i & SEG_PFX_MASK) == SEG_PFX_VAL) begin
            s_nxt.seg_ovr = 1'b1;
            s_nxt.seg_ovr_sel = byte_i[4:3];
            s_nxt.st = CCOD_IDLE;
          end else begin
            // lock follows the prefix onto whatever opcode comes next
            s_nxt.lock = s_r.lock_pend;
            s_nxt.lock_pend = 1'b0;
            case (byte_i)
              OP_CARRY_CLEAR: s_nxt.carry = 1'b0;
              OP_CARRY_SET: s_nxt.carry = 1'b1;
              OP_CARRY_INVERT: s_nxt.carry = ~s_r.carry;
              OP_DIR_CLEAR: s_nxt.dir = 1'b0;
              OP_DIR_SET: s_nxt.dir = 1'b1;
              OP_INT_DISABLE: s_nxt.ie = 1'b0;
              OP_INT_ENABLE: s_nxt.ie = 1'b1;
              OP_LOCK: begin
                s_nxt.lock_pend = 1'b1;
                s_nxt.cnt = CYC_LOCK - 4'h2;
              end
              OP_HALT: begin
                s_nxt.cnt = CYC_HALT - 4'h2;
                s_nxt.halted = 1'b1;
              end
              OP_WAIT: begin
                s_nxt.cnt = CYC_WAIT - 4'h2;
                s_nxt.st = CCOD_WAITING;
              end
              OP_NOP: s_nxt.cnt = CYC_NOP - 4'h2;
              default: begin
                // other opcodes only matter here if they carry an operand byte
                s_nxt.st = modrm_op_i ? CCOD_MODRM : CCOD_IDLE;
              end
            endcase
          end
        end
      end
      CCOD_MODRM: begin
        if (byte_valid_i) begin
          s_nxt.mod = byte_i[7:6];
          s_nxt.rm = byte_i[2:0];
          s_nxt.disp = 16'h0000;
          s_nxt.reg_wide = s_r.wide;
          s_nxt.reg_op = 1'b0;
          s_nxt.reg_sel = byte_i[5:3];
          if (byte_i[7:6] == MOD_REG) begin
            s_nxt.reg_op = 1'b1;
            s_nxt.reg_sel = byte_i[2:0];
            s_nxt.st = CCOD_IDLE;
            s_nxt.seg_ovr = 1'b0;
            s_nxt.lock = 1'b0;
          end else if (byte_i[7:6] == MOD_NODISP && byte_i[2:0] != RM_DIRECT) begin
            s_nxt.cnt = CYC_EA - 4'h1;
            s_nxt.st = CCOD_BUSY;
          end else begin
            s_nxt.st = CCOD_DISP_LO;
          end
        end
      end
      CCOD_DISP_LO: begin
        if (byte_valid_i) begin
          if (s_r.mod == MOD_DISP8) begin
            s_nxt.disp = {{8{byte_i[7]}}, byte_i};
            s_nxt.cnt = CYC_EA - 4'h1;
            s_nxt.st = CCOD_BUSY;
          end else begin
            s_nxt.disp = {8'h00, byte_i};
            s_nxt.st = CCOD_DISP_HI;
          end
        end
      end
      CCOD_DISP_HI: begin
        if (byte_valid_i) begin
          s_nxt.disp = {byte_i, s_r.disp[7:0]};
          s_nxt.cnt = CYC_EA - 4'h1;
          s_nxt.st = CCOD_BUSY;
        end
      end
      CCOD_BUSY: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else if (s_r.halted) begin
          s_nxt.st = CCOD_HALTED;
        end else begin
          s_nxt.st = CCOD_IDLE;
          // plain opcodes keep the last address and segment
          if (s_r.mod != MOD_REG) begin
            s_nxt.ea_valid = 1'b1;
            s_nxt.ea = ea_calc;
            if (s_r.str_dst && (s_r.rm == 3'h1 || s_r.rm == 3'h3 || s_r.rm == 3'h5)) begin
              s_nxt.seg = SEG_EXTRA;
            end else if (s_r.seg_ovr) begin
              s_nxt.seg = s_r.seg_ovr_sel;
            end else if (uses_bp) begin
              s_nxt.seg = SEG_STACK;
            end else begin
              s_nxt.seg = SEG_DATA;
            end
            s_nxt.seg_ovr = 1'b0;
            // no second pulse after the word transfer tail
            s_nxt.mod = MOD_REG;
          end
          // word operand in memory: extra bus cycles before release
          if (s_r.wide && mem_xfer_i && s_r.mod != MOD_REG) begin
            s_nxt.cnt = CYC_WORD_XFER - 4'h1;
            s_nxt.wide = 1'b0;
            s_nxt.st = CCOD_BUSY;
          end else begin
            s_nxt.lock = 1'b0;
          end
        end
      end
      CCOD_HALTED: s_nxt.st = CCOD_HALTED;
      CCOD_WAITING: begin
        // wait holds the core until test goes active
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else if (test_active_i) begin
          s_nxt.st = CCOD_IDLE;
        end
      end
      default: s_nxt.st = CCOD_IDLE;
    endcase
    // reset of the non-memory path clears a leftover mod
    if (s_r.st == CCOD_IDLE && byte_valid_i && !modrm_op_i) begin
      s_nxt.mod = MOD_REG;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_r <= '{st: CCOD_IDLE, mod: MOD_REG, seg: SEG_DATA, default: '0};
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic ready_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ready_r <= 1'b0;
    end else if (clk_en_i) begin
      ready_r <= (s_nxt.st == CCOD_IDLE) || (s_nxt.st == CCOD_MODRM) ||
                 (s_nxt.st == CCOD_DISP_LO) || (s_nxt.st == CCOD_DISP_HI);
    end
  end

  assign byte_ready_o = ready_r;
  assign carry_o = s_r.carry;
  assign direction_o = s_r.dir;
  assign int_enable_o = s_r.ie;
  assign halted_o = s_r.halted;
  assign bus_lock_o = s_r.lock;
  assign ea_valid_o = s_r.ea_valid;
  assign effective_address_o = s_r.ea;
  assign segment_o = s_r.seg;
  assign reg_operand_o = s_r.reg_op;
  assign reg_sel_o = s_r.reg_sel;
  assign reg_wide_o = s_r.reg_wide;
  assign disp_o = s_r.disp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence carry_set_seq;
    byte_ready_o && byte_valid_i && s_r.st == CCOD_IDLE && byte_i == OP_CARRY_SET;
  endsequence
  carry_set_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i throughout (carry_set_seq ##1 1'b1) |-> carry_o)
    else $error("carry set op did not set carry");
  dir_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && s_r.st == CCOD_IDLE && byte_valid_i && byte_i == OP_DIR_CLEAR) |=> !direction_o)
    else $error("direction clear failed");
  int_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && s_r.st == CCOD_IDLE && byte_valid_i && byte_i == OP_INT_ENABLE) |=> int_enable_o)
    else $error("interrupt enable failed");
  halt_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_r.st == CCOD_HALTED) |=> (s_r.st == CCOD_HALTED))
    else $error("halt state left");
  disp8_sign_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && s_r.st == CCOD_DISP_LO && byte_valid_i && s_r.mod == MOD_DISP8)
      |=> disp_o == {{8{$past(byte_i[7])}}, $past(byte_i)})
    else $error("8-bit displacement not sign extended");
  disp16_order_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && s_r.st == CCOD_DISP_HI && byte_valid_i) |=> disp_o[15:8] == $past(byte_i))
    else $error("high displacement byte misplaced");
  ea_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !clk_en_i)
    (s_r.st == CCOD_DISP_HI && byte_valid_i) |=> !ea_valid_o [*4])
    else $error("address ready too early");
  reg_mode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && s_r.st == CCOD_MODRM && byte_valid_i && byte_i[7:6] == MOD_REG)
      |=> reg_operand_o && reg_sel_o == $past(byte_i[2:0]))
    else $error("register form not decoded");
  stack_seg_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ea_valid_o && !$past(s_r.seg_ovr) && !$past(s_r.str_dst) && $past(uses_bp)) |-> segment_o == SEG_STACK)
    else $error("base pointer operand not in stack segment");
endmodule : ccod_decoder

/* testbench/ccod_byte_source.sv */
// instruction byte stream model for the decoder
`timescale 1ns/1ps
module ccod_byte_source (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic stall_i,
  input wire logic byte_ready_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output int taken_o
);
  logic [7:0] q [$];
  logic took;
  logic gap = 1'b0;
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
    taken_o = 0;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  // a byte stays offered until taken; under stall a new byte is offered only on every other cycle
  always @(posedge sys_clk_i) begin
    took = byte_valid_o && byte_ready_i && clk_en_i;
    gap <= ~gap;
    if (rst_i) begin
      q.delete();
      byte_valid_o <= 1'b0;
      byte_o <= ~byte_o;
    end else begin
      if (took) begin
        void'(q.pop_front());
        taken_o <= taken_o + 1;
      end
      if (q.size() > 0 && ((byte_valid_o && !took) || !stall_i || gap)) begin
        byte_valid_o <= 1'b1;
        byte_o <= q[0];
      end else begin
        // idle bus shows the inverse so a stale byte never looks fresh
        byte_valid_o <= 1'b0;
        byte_o <= ~byte_o;
      end
    end
  end
endmodule : ccod_byte_source

/* testbench/testbench.sv */
// self-checking bench for the control opcode and operand decoder
`timescale 1ns/1ps
module testbench;
  import ccod_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, modrm_op = 1'b0, word_op = 1'b0;
  logic mem_xfer = 1'b1, string_dest = 1'b0, test_active = 1'b0, stall = 1'b0;
  logic [15:0] bx = 16'h1000, bp = 16'h2000, si = 16'h0030, di = 16'h0004;
  logic byte_valid, byte_ready, carry, direction, int_enable, halted, bus_lock, ea_valid;
  logic reg_operand, reg_wide, ea_seen = 1'b0, lock_seen = 1'b0;
  logic [7:0] byte_d;
  logic [15:0] ea, disp;
  logic [1:0] segment;
  logic [2:0] reg_sel;
  logic [7:0] bq [$];
  int taken, num_errors = 0, checked = 0;
  wire [2:0] flags = {int_enable, direction, carry};
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ea_seen <= ea_seen | ea_valid;
    lock_seen <= lock_seen | bus_lock;
  end
  ccod_decoder i_ccod_decoder (.sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(clk_en), .byte_valid_i(byte_valid),
    .byte_i(byte_d), .modrm_op_i(modrm_op), .word_op_i(word_op), .mem_xfer_i(mem_xfer),
    .string_dest_i(string_dest), .test_active_i(test_active), .bx_i(bx), .bp_i(bp), .si_i(si), .di_i(di),
    .byte_ready_o(byte_ready), .carry_o(carry), .direction_o(direction), .int_enable_o(int_enable),
    .halted_o(halted), .bus_lock_o(bus_lock), .ea_valid_o(ea_valid), .effective_address_o(ea),
    .segment_o(segment), .reg_operand_o(reg_operand), .reg_sel_o(reg_sel), .reg_wide_o(reg_wide), .disp_o(disp));
  ccod_byte_source i_ccod_byte_source (.sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(clk_en), .stall_i(stall),
    .byte_ready_i(byte_ready), .byte_valid_o(byte_valid), .byte_o(byte_d), .taken_o(taken));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic hang;
    num_errors++;
    $display("ERROR at %0t ns: wait limit reached, got %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  endtask : hang
  task automatic send;
    int n;
    int k;
    @(negedge sys_clk);
    n = taken + bq.size();
    foreach (bq[i]) i_ccod_byte_source.push(bq[i]);
    bq.delete();
    k = 0;
    while (taken < n) begin
      @(negedge sys_clk);
      k++;
      if (k > 60) hang();
    end
  endtask : send
  task automatic wait_ready(output int k);
    k = 0;
    while (byte_ready !== 1'b1) begin
      @(negedge sys_clk);
      k++;
      if (k > 60) hang();
    end
  endtask : wait_ready
  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({10'h0, carry, direction, int_enable, halted, bus_lock, ea_valid}, 16'h0000);
    check({14'h0, segment}, {14'h0, SEG_DATA});
  endtask : do_reset
  function automatic logic [15:0] ea_exp(input logic [1:0] md, input logic [2:0] rm);
    logic [15:0] d;
    logic [15:0] b [8];
    b = '{bx + si, bx + di, bp + si, bp + di, si, di, bp, bx};
    d = (md == MOD_DISP8) ? 16'hff9c : 16'h1234;
    if (md == MOD_NODISP) begin
      d = 16'h0000;
      if (rm == RM_DIRECT) return 16'h1234;
    end
    return b[rm] + d;
  endfunction : ea_exp
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_flags;
    logic [7:0] op [8] = '{OP_CARRY_SET, OP_CARRY_INVERT, OP_CARRY_INVERT, OP_CARRY_CLEAR,
                           OP_DIR_SET, OP_DIR_CLEAR, OP_INT_ENABLE, OP_INT_DISABLE};
    int sel [8] = '{0, 0, 0, 0, 1, 1, 2, 2};
    for (int i = 0; i < 8; i++) begin
      bq.push_back(op[i]);
      send();
      check({15'h0, flags[sel[i]]}, {15'h0, !i[0]});
      check({15'h0, byte_ready}, 16'h0000);
      @(negedge sys_clk);
      check({15'h0, byte_ready}, 16'h0001);
    end
  endtask : t_flags
  task automatic t_addr(input logic [7:0] pfx, input logic [1:0] md, input logic [2:0] rm,
                        input logic [1:0] seg, input bit timed, output int rdy);
    int k;
    if (pfx != 8'h00) bq.push_back(pfx);
    bq.push_back(8'h8b);
    bq.push_back({md, 3'h2, rm});
    if (md == MOD_DISP8) bq.push_back(8'h9c);
    if (md == MOD_DISP16 || (md == MOD_NODISP && rm == RM_DIRECT)) begin
      bq.push_back(8'h34);
      bq.push_back(8'h12);
    end
    send();
    k = 0;
    while (ea_valid !== 1'b1) begin
      @(negedge sys_clk);
      k++;
      if (k > 40) hang();
    end
    if (timed) check(16'(k), 16'h0004);
    check(ea, ea_exp(md, rm));
    check({14'h0, segment}, {14'h0, seg});
    wait_ready(rdy);
  endtask : t_addr
  task automatic t_forms;
    int r, r2;
    logic [1:0] seg;
    @(posedge sys_clk);
    modrm_op <= 1'b1;
    for (int md = 0; md < 3; md++) begin
      for (int rm = 0; rm < 8; rm++) begin
        seg = (rm == 2 || rm == 3 || (rm == 6 && md != 0)) ? SEG_STACK : SEG_DATA;
        t_addr(8'h00, 2'(md), 3'(rm), seg, 1'b1, r);
      end
    end
    @(posedge sys_clk);
    word_op <= 1'b1;
    t_addr(8'h00, MOD_DISP16, 3'h7, SEG_DATA, 1'b1, r2);
    check(16'(r2), 16'(r + 4));
    @(posedge sys_clk);
    word_op <= 1'b0;
  endtask : t_forms
  task automatic t_override;
    int r;
    for (int s = 0; s < 4; s++) t_addr(8'h26 | 8'(s << 3), MOD_NODISP, 3'h0, 2'(s), 1'b0, r);
    @(posedge sys_clk);
    string_dest <= 1'b1;
    t_addr(8'h2e, MOD_DISP8, 3'h5, SEG_EXTRA, 1'b0, r);
    @(posedge sys_clk);
    string_dest <= 1'b0;
  endtask : t_override
  task automatic t_regs;
    int r;
    stall <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      for (int rm = 0; rm < 8; rm++) begin
        @(posedge sys_clk);
        word_op <= w[0];
        bq.push_back(8'h8b);
        bq.push_back({2'h3, 3'(rm), 3'(rm)});
        ea_seen = 1'b0;
        send();
        wait_ready(r);
        check({12'h0, ea_seen, reg_operand, reg_wide, 1'b0}, {12'h0, 1'b0, 1'b1, w[0], 1'b0});
        check({13'h0, reg_sel}, 16'(rm));
      end
    end
    stall <= 1'b0;
    word_op <= 1'b0;
    modrm_op <= 1'b0;
  endtask : t_regs
  task automatic t_misc;
    int r, n;
    logic [2:0] flg;
    flg = flags;
    lock_seen = 1'b0;
    bq.push_back(OP_LOCK);
    bq.push_back(OP_NOP);
    send();
    wait_ready(r);
    repeat (2) @(negedge sys_clk);
    check({14'h0, lock_seen, bus_lock}, 16'h0002);
    check({13'h0, flags}, {13'h0, flg});
    bq.push_back(OP_WAIT);
    send();
    repeat (10) begin
      @(negedge sys_clk);
      check({15'h0, byte_ready}, 16'h0000);
    end
    @(posedge sys_clk);
    test_active <= 1'b1;
    wait_ready(r);
    @(posedge sys_clk);
    test_active <= 1'b0;
    bq.push_back(OP_HALT);
    send();
    repeat (3) @(negedge sys_clk);
    check({15'h0, halted}, 16'h0001);
    n = taken;
    i_ccod_byte_source.push(OP_NOP);
    repeat (10) @(negedge sys_clk);
    check(16'(taken), 16'(n));
    do_reset();
  endtask : t_misc
  initial begin
    do_reset();
    t_flags();
    t_forms();
    t_override();
    t_regs();
    t_misc();
    test_done();
  end
endmodule : testbench
